/* File: hw/sim_status_pkg.sv */
// Package: offsets, field positions, reset values and types of the status registers
package sim_status_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BREAK_STATUS  = 16'hFE00;
  localparam logic [15:0] IDX_RESET_CAUSE   = 16'hFE01;
  localparam logic [15:0] IDX_BREAK_FLAG_CT = 16'hFE03;
  localparam logic [15:0] IDX_EVT_STATUS    = 16'hFE04;
  localparam logic [15:0] IDX_EVT_MASK      = 16'hFE05;

  // Field positions
  localparam int BRK_WAIT_BIT   = 1;
  localparam int BRK_CLR_EN_BIT = 7;
  localparam int RC_POR_BIT     = 7;
  localparam int RC_PIN_BIT     = 6;
  localparam int RC_WDOG_BIT    = 5;
  localparam int RC_BAD_OP_BIT  = 4;
  localparam int RC_BAD_ADR_BIT = 3;
  localparam int RC_LOW_VLT_BIT = 1;

  // Reset values
  localparam logic [7:0] RESET_CAUSE_RST = 8'h80;
  localparam logic [7:0] RESET_CAUSE_POR = 8'h80;
  localparam logic [7:0] BREAK_STAT_RST  = 8'h00;
  localparam logic [7:0] BREAK_CTL_RST   = 8'h00;
  localparam logic [7:0] EVT_STATUS_RST  = 8'h00;
  localparam logic [7:0] EVT_MASK_RST    = 8'h00;

  // Timing counts, in oscillator clock cycles
  localparam int PIN_LOW_CYCLES = 67;
  localparam int BUS_CLK_DIV    = 2;

  // One flag per reset source, in reset cause bit order
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic bad_op;
    logic bad_adr;
    logic low_volt;
  } reset_src_t;

  // APB bus state
  typedef enum logic [2:0] {
    APB_IDLE   = 3'b001,
    APB_ACCESS = 3'b010,
    APB_DONE   = 3'b100
  } apb_state_t;

endpackage : sim_status_pkg

/* File: hw/bus_clk_div.sv */
// Module: divides the clock generator output by two to form the bus clock
`timescale 1ns/1ns
module bus_clk_div #(
  parameter int DIV = sim_status_pkg::BUS_CLK_DIV
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Divided clock
  output logic      bus_clk_q,
  output logic      bus_tick_q
);

  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);

  logic [CW-1:0] cnt_q;

  // Toggle every half period; tick marks each rising bus edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= '0;
      bus_clk_q  <= 1'b0;
      bus_tick_q <= 1'b0;
    end else if (ce) begin
      if (cnt_q == HALF) begin
        cnt_q      <= '0;
        bus_clk_q  <= ~bus_clk_q;
        bus_tick_q <= ~bus_clk_q;
      end else begin
        cnt_q      <= cnt_q + CW'(1);
        bus_tick_q <= 1'b0;
      end
    end
  end

endmodule : bus_clk_div

/* File: hw/system_integration_status_regs.sv */
// Module: system integration status and control registers on APB
// Summary of operation
// - Break status at FE00, bit1 wait flag
// - Writing zero to bit1 clears wait flag
// - Read-only reset cause register at FE01
// - Break flag control at FE03, bit7 writable
// - Bus clock is clock generator divided two
// - Power-on sets POR, clears other cause bits
// - Each reset source sets its own flag
// - Pin flag needs 67 low cycles, no power-on/low-voltage
`timescale 1ns/1ns
module system_integration_status_regs #(
  parameter int AW = 18
) (
  // Clock, reset, enable
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      ce,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [AW-1:0]             paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Reset sources and break events
  input  wire logic                      power_on_pulse,
  input  wire logic                      reset_pin_n,
  input  wire sim_status_pkg::reset_src_t reset_evt,
  input  wire logic                      break_wait_evt,
  // Block outputs
  output logic                           internal_reset,
  output logic                           break_clear_flag_enable,
  output logic                           bus_clk,
  output logic                           bus_tick,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Word address match against a register index
  function automatic logic hit(input logic [AW-1:0] a, input logic [15:0] idx);
    hit = (a == AW'({idx, 2'b00}));
  endfunction : hit

  sim_status_pkg::apb_state_t st_q;
  logic [7:0]  brk_stat_q;
  logic [7:0]  brk_ctl_q;
  logic [7:0]  cause_q;
  logic [7:0]  evt_stat_q;
  logic [7:0]  evt_mask_q;
  logic [6:0]  pin_cnt_q;
  logic        pin_blk_q;
  logic        pin_done_q;
  logic        wr_en;
  logic        lane0;
  logic        mapped;
  logic [7:0]  rd_mux;
  logic        pin_evt;
  logic        any_rst;
  logic [7:0]  evt_bits;

  assign lane0  = pstrb[0];
  assign mapped = hit(paddr, sim_status_pkg::IDX_BREAK_STATUS)
               | hit(paddr, sim_status_pkg::IDX_RESET_CAUSE)
               | hit(paddr, sim_status_pkg::IDX_BREAK_FLAG_CT)
               | hit(paddr, sim_status_pkg::IDX_EVT_STATUS)
               | hit(paddr, sim_status_pkg::IDX_EVT_MASK);
  // Writes land only on the completing edge of the access phase
  assign wr_en  = ce & psel & penable & pwrite & pready & mapped & lane0;

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait-free access cycle, answer registered

  // Read mux, unused bits read zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit(paddr, sim_status_pkg::IDX_BREAK_STATUS)) begin
      rd_mux = brk_stat_q;
    end else if (hit(paddr, sim_status_pkg::IDX_RESET_CAUSE)) begin
      rd_mux = cause_q;
    end else if (hit(paddr, sim_status_pkg::IDX_BREAK_FLAG_CT)) begin
      rd_mux = brk_ctl_q;
    end else if (hit(paddr, sim_status_pkg::IDX_EVT_STATUS)) begin
      rd_mux = evt_stat_q;
    end else if (hit(paddr, sim_status_pkg::IDX_EVT_MASK)) begin
      rd_mux = evt_mask_q;
    end
  end

  // Setup cycle loads the answer so pready comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= sim_status_pkg::APB_IDLE;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      case (st_q)
        sim_status_pkg::APB_IDLE: begin
          if (psel && !penable) begin
            st_q    <= sim_status_pkg::APB_ACCESS;
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
            pslverr <= ~mapped;
          end
        end
        sim_status_pkg::APB_ACCESS: begin
          if (psel && penable) begin
            st_q    <= sim_status_pkg::APB_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
        default: begin
          st_q   <= sim_status_pkg::APB_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External pin reset qualification

  // Pin counts only a long low; power-on or low voltage inside the low blocks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt_q  <= 7'h00;
      pin_blk_q  <= 1'b0;
      pin_done_q <= 1'b0;
    end else if (ce) begin
      if (reset_pin_n) begin
        pin_cnt_q  <= 7'h00;
        pin_blk_q  <= 1'b0;
        pin_done_q <= 1'b0;
      end else begin
        if (pin_cnt_q != 7'(sim_status_pkg::PIN_LOW_CYCLES)) begin
          pin_cnt_q <= pin_cnt_q + 7'h01;
        end
        if (power_on_pulse || reset_evt.por || reset_evt.low_volt) begin
          pin_blk_q <= 1'b1;
        end
        if (pin_evt) begin
          pin_done_q <= 1'b1;
        end
      end
    end
  end

  // One event per qualified low, on the 67th low cycle
  assign pin_evt = ~reset_pin_n & ~pin_done_q & ~pin_blk_q
                 & ~power_on_pulse & ~reset_evt.por & ~reset_evt.low_volt
                 & (pin_cnt_q == 7'(sim_status_pkg::PIN_LOW_CYCLES - 1));

  assign any_rst = power_on_pulse | pin_evt | reset_evt.por | reset_evt.pin
                 | reset_evt.wdog | reset_evt.bad_op | reset_evt.bad_adr
                 | reset_evt.low_volt;

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause register

  // Power-on wipes history; other sources only add their own bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= sim_status_pkg::RESET_CAUSE_RST;
    end else if (ce) begin
      if (power_on_pulse || reset_evt.por) begin
        cause_q <= sim_status_pkg::RESET_CAUSE_POR;
      end else begin
        if (pin_evt || reset_evt.pin) begin
          cause_q[sim_status_pkg::RC_PIN_BIT] <= 1'b1;
        end
        if (reset_evt.wdog) begin
          cause_q[sim_status_pkg::RC_WDOG_BIT] <= 1'b1;
        end
        if (reset_evt.bad_op) begin
          cause_q[sim_status_pkg::RC_BAD_OP_BIT] <= 1'b1;
        end
        if (reset_evt.bad_adr) begin
          cause_q[sim_status_pkg::RC_BAD_ADR_BIT] <= 1'b1;
        end
        if (reset_evt.low_volt) begin
          cause_q[sim_status_pkg::RC_LOW_VLT_BIT] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break status and break flag control

  // Internal reset restores defaults; a set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_stat_q <= sim_status_pkg::BREAK_STAT_RST;
    end else if (ce) begin
      if (any_rst) begin
        brk_stat_q <= sim_status_pkg::BREAK_STAT_RST;
      end else if (break_wait_evt) begin
        brk_stat_q[sim_status_pkg::BRK_WAIT_BIT] <= 1'b1;
      end else if (wr_en && hit(paddr, sim_status_pkg::IDX_BREAK_STATUS)
                   && !pwdata[sim_status_pkg::BRK_WAIT_BIT]) begin
        brk_stat_q[sim_status_pkg::BRK_WAIT_BIT] <= 1'b0;
      end
    end
  end

  // Only bit 7 is writable; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_ctl_q <= sim_status_pkg::BREAK_CTL_RST;
    end else if (ce) begin
      if (any_rst) begin
        brk_ctl_q <= sim_status_pkg::BREAK_CTL_RST;
      end else if (wr_en && hit(paddr, sim_status_pkg::IDX_BREAK_FLAG_CT)) begin
        brk_ctl_q[sim_status_pkg::BRK_CLR_EN_BIT] <=
          pwdata[sim_status_pkg::BRK_CLR_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt

  // Same layout as reset cause, plus break wait in bit 1's neighbour bit 0
  assign evt_bits = {power_on_pulse | reset_evt.por, pin_evt | reset_evt.pin,
                     reset_evt.wdog, reset_evt.bad_op, reset_evt.bad_adr,
                     1'b0, reset_evt.low_volt, break_wait_evt};

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_q <= sim_status_pkg::EVT_STATUS_RST;
      evt_mask_q <= sim_status_pkg::EVT_MASK_RST;
    end else if (ce) begin
      if (wr_en && hit(paddr, sim_status_pkg::IDX_EVT_STATUS)) begin
        evt_stat_q <= (evt_stat_q & ~pwdata[7:0]) | evt_bits;
      end else begin
        evt_stat_q <= evt_stat_q | evt_bits;
      end
      if (wr_en && hit(paddr, sim_status_pkg::IDX_EVT_MASK)) begin
        evt_mask_q <= pwdata[7:0];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq                     <= 1'b0;
      internal_reset          <= 1'b0;
      break_clear_flag_enable <= 1'b0;
    end else if (ce) begin
      irq                     <= |(evt_stat_q & evt_mask_q);
      internal_reset          <= any_rst;
      break_clear_flag_enable <= brk_ctl_q[sim_status_pkg::BRK_CLR_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock: pclk stands for the clock generator output

  bus_clk_div #(
    .DIV (sim_status_pkg::BUS_CLK_DIV)
  ) u_bus_clk_div (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .bus_clk_q  (bus_clk),
    .bus_tick_q (bus_tick)
  );

endmodule : system_integration_status_regs

/* File: tb/cpu_bus_model.sv */
// CPU side bus master model for the status registers
`timescale 1ns/1ns
module cpu_bus_model #(
  parameter int AW = 18
) (
  // Clock
  input  wire logic          pclk,
  // Requests
  output logic               psel,
  output logic               penable,
  output logic               pwrite,
  output logic [AW-1:0]      paddr,
  output logic [31:0]        pwdata,
  // Answers
  input  wire logic          pready,
  input  wire logic [31:0]   prdata,
  input  wire logic          pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end

  // One transfer; ready, data and error are taken at the rising edge that completes it
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : cpu_bus_model

/* File: tb/sim_status_chk.sv */
// Checker: port relations of the status register block
`timescale 1ns/1ns
module sim_status_chk #(
  parameter int AW = 18
) (
  // Clock, reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       ce,
  // APB
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [AW-1:0]              paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic                       pready,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  // Events and outputs
  input wire logic                       power_on_pulse,
  input wire sim_status_pkg::reset_src_t reset_evt,
  input wire logic                       internal_reset,
  input wire logic                       break_clear_flag_enable,
  input wire logic                       bus_clk,
  input wire logic                       bus_tick
);
  localparam logic [AW-1:0] A_BS  = AW'({sim_status_pkg::IDX_BREAK_STATUS, 2'b00});
  localparam logic [AW-1:0] A_RC  = AW'({sim_status_pkg::IDX_RESET_CAUSE, 2'b00});
  localparam logic [AW-1:0] A_BFC = AW'({sim_status_pkg::IDX_BREAK_FLAG_CT, 2'b00});
  // Read completing, write completing, power-on or any reset_evt source
  wire rd_q = psel && penable && pready && !pwrite;
  wire wr_q = psel && penable && pready && pwrite;
  wire evt = power_on_pulse || (|reset_evt);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_brk_fields: assert property (rd_q && paddr == A_BS |-> (prdata & ~32'h2) == 32'h0)
    else $error("break status reserved bits set");
  a_cause_zero_bits: assert property (rd_q && paddr == A_RC |-> (prdata & ~32'hFA) == 32'h0)
    else $error("reset cause fixed bits set");
  a_bfc_fields: assert property (rd_q && paddr == A_BFC |-> (prdata & ~32'h80) == 32'h0)
    else $error("flag control reserved bits set");
  a_bfc_write: assert property (wr_q && pstrb[0] && paddr == A_BFC && !evt ##1 !evt
    |=> break_clear_flag_enable == $past(pwdata[7], 2))
    else $error("flag control bit not written");
  // Release edge excluded: the divider is still held in reset there
  a_bus_clk_half: assert property (presetn && ce |=> bus_clk != $past(bus_clk))
    else $error("bus clock not toggling");
  a_bus_clk_hold: assert property (presetn && !ce |=> bus_clk == $past(bus_clk))
    else $error("bus clock moved while frozen");
  a_tick_tracks: assert property (bus_tick == bus_clk)
    else $error("bus tick off bus clock");
  a_internal_reset_event: assert property (ce && evt |=> internal_reset)
    else $error("no internal reset after event");

  c_cause_read: cover property (rd_q && paddr == A_RC);
  c_unmapped: cover property (pslverr);
  c_internal_reset: cover property (internal_reset);
endmodule : sim_status_chk

bind system_integration_status_regs sim_status_chk #(.AW(AW)) chk_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .power_on_pulse(power_on_pulse),
  .reset_evt(reset_evt), .internal_reset(internal_reset),
  .break_clear_flag_enable(break_clear_flag_enable), .bus_clk(bus_clk), .bus_tick(bus_tick));

/* File: tb/test_system_integration_status_regs.sv */
// Testbench: status and control registers driven from a CPU model
`timescale 1ns/1ns
module test_system_integration_status_regs;
  localparam logic [17:0] A_BS  = {sim_status_pkg::IDX_BREAK_STATUS, 2'b00};
  localparam logic [17:0] A_RC  = {sim_status_pkg::IDX_RESET_CAUSE, 2'b00};
  localparam logic [17:0] A_BFC = {sim_status_pkg::IDX_BREAK_FLAG_CT, 2'b00};
  localparam logic [17:0] A_ES  = {sim_status_pkg::IDX_EVT_STATUS, 2'b00};
  localparam logic [17:0] A_EM  = {sim_status_pkg::IDX_EVT_MASK, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, power_on_pulse = 1'b0, reset_pin_n = 1'b1;
  logic break_wait_evt = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
  logic ce = 1'b1, brk_clr_en;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rq, d, exp;
  logic re;
  sim_status_pkg::reset_src_t reset_evt = '0;
  int miscompares = 0, checks_done = 0, cyc = 0;

  initial forever #10 pclk = ~pclk;

  cpu_bus_model cpu_bus_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  // Byte strobes tied high: every write is a full word
  system_integration_status_regs system_integration_status_regs_i (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .power_on_pulse(power_on_pulse), .reset_pin_n(reset_pin_n),
    .reset_evt(reset_evt), .break_wait_evt(break_wait_evt), .internal_reset(),
    .break_clear_flag_enable(brk_clr_en), .bus_clk(), .bus_tick(), .irq(irq));

  task automatic give_verdict;
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, want, got);
    end
  endtask : check

  task automatic rd(input logic [17:0] a);
    cpu_bus_model_i.xfer(1'b0, a, 32'h0, rq, re);
  endtask : rd

  task automatic wr(input logic [17:0] a, input logic [31:0] v);
    cpu_bus_model_i.xfer(1'b1, a, v, rq, re);
  endtask : wr

  // One-cycle reset source pulse; index 6 means power-on
  task automatic src(input int b);
    @(posedge pclk);
    if (b == 6) power_on_pulse <= 1'b1;
    else reset_evt <= sim_status_pkg::reset_src_t'(6'(1 << b));
    @(posedge pclk);
    power_on_pulse <= 1'b0;
    reset_evt <= '0;
  endtask : src

  // Pin held low for n sampled edges, optional low-voltage pulse inside
  task automatic pin_low(input int n, input logic lv);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (n / 2) @(posedge pclk);
    reset_evt.low_volt <= lv;
    @(posedge pclk);
    reset_evt.low_volt <= 1'b0;
    repeat (n - n / 2 - 1) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask : pin_low

  // Cause register bit of reset source index b
  function automatic logic [31:0] cause_bit(input int b);
    return (b == 0) ? 32'h2 : 32'(8'h01 << (b + 2));
  endfunction : cause_bit

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_BS);  check("brk_rst", rq, 32'h0);
    rd(A_RC);  check("cause_rst", rq, 32'h80);
    rd(A_BFC); check("bfc_rst", rq, 32'h0);
    rd(A_RC + 18'h4); check("unmapped", {rq[30:0], re}, 32'h1);
    wr(A_RC, 32'hFF); rd(A_RC); check("cause_ro", rq, 32'h80);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $urandom;
      wr(A_BFC, d); rd(A_BFC); check("bfc", rq, {24'h0, d[7], 7'h0});
      check("bfc_pin", {31'h0, brk_clr_en}, {31'h0, d[7]});
    end
    wr(A_EM, 32'h1);
    @(posedge pclk) break_wait_evt <= 1'b1;
    @(posedge pclk) break_wait_evt <= 1'b0;
    rd(A_BS); check("brk_set", rq, 32'h2);
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(A_BS, 32'hFF); rd(A_BS); check("brk_w1", rq, 32'h2);
    wr(A_BS, 32'h0);  rd(A_BS); check("brk_w0", rq, 32'h0);
    wr(A_ES, 32'h1); repeat (2) @(negedge pclk);
    check("irq_off", {31'h0, irq}, 32'h0);
    // Break event while frozen must leave no trace
    @(posedge pclk) ce <= 1'b0;
    break_wait_evt <= 1'b1;
    @(posedge pclk) ce <= 1'b1;
    break_wait_evt <= 1'b0;
    rd(A_BS); check("brk_frozen", rq, 32'h0);
    wr(A_BFC, 32'h80);
    exp = 32'h80;
    for (int b = 4; b >= 0; b--) begin
      src(b); exp |= cause_bit(b);
      rd(A_RC); check("cause_acc", rq, exp);
    end
    check("bfc_evt", {31'h0, brk_clr_en}, 32'h0);
    src(6); rd(A_RC); check("cause_por", rq, 32'h80);
    pin_low(66, 1'b0); rd(A_RC); check("pin_66", rq, 32'h80);
    pin_low(67, 1'b0); rd(A_RC); check("pin_67", rq, 32'hC0);
    src(6); pin_low(67, 1'b1); rd(A_RC); check("pin_lowv", rq, 32'h82);
    give_verdict();
  end
endmodule : test_system_integration_status_regs
